// File: logic/reset_and_clock_select_defines.vh
// Constants for the reset sequencer and system clock selector
// Summary of operation
// - Reset pin acts only when option enables it
// - Reset pin low holds reset, high runs
// - Pin honoured at power-up and while running
// - Stay in reset until the pin reads high
// - Init registers, then wait oscillator warm-up
// - After warm-up start execution at address zero
// - High or slow clock feeds instruction divider
// - Slow clock comes from internal slow RC
// - Normal mode divides high clock by 1 to 16
// - Slow mode fixes instruction clock at quarter
// - Internal fast RC limits divider to 4..16
// - Noise filter forbids rates above divide-by-4
// - Filter cleans external oscillator, RC and crystal
// - Options: fast RC, crystals 4M/12M/32k, external RC
// - RTC option: system on fast RC, RTC on crystal
// - Control bit 2: 0 high clock, 1 slow clock
`ifndef RESET_AND_CLOCK_SELECT_DEFINES_VH
`define RESET_AND_CLOCK_SELECT_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OPT_REG_ADDR        8'h00
`define CTRL_REG_ADDR       8'h04
`define STAT_REG_ADDR       8'h08

// ----------------------------------------------------------------
// Option register fields and reset value
// ----------------------------------------------------------------
`define OPT_PIN_EN_BIT      0
`define OPT_FILT_EN_BIT     1
`define OPT_HIGH_CLOCK_OPTION_SEL_LSB        2
`define OPT_HIGH_CLOCK_OPTION_SEL_MSB        4
`define OPT_DIV_LSB         5
`define OPT_DIV_MSB         7
`define OPT_RESET_VAL       8'h41

// ----------------------------------------------------------------
// Control register fields and reset value
// ----------------------------------------------------------------
`define CTRL_SLOW_BIT       2
`define CTRL_RESET_VAL      8'h00

// ----------------------------------------------------------------
// High clock option codes
// ----------------------------------------------------------------
`define HIGH_CLOCK_OPTION_SEL_FAST_RC_ONLY   3'h0
`define HIGH_CLOCK_OPTION_SEL_FAST_RC_RTC    3'h1
`define HIGH_CLOCK_OPTION_SEL_EXT_RC         3'h2
`define HIGH_CLOCK_OPTION_SEL_XTAL_32K       3'h3
`define HIGH_CLOCK_OPTION_SEL_XTAL_12M       3'h4
`define HIGH_CLOCK_OPTION_SEL_XTAL_4M        3'h5

// ----------------------------------------------------------------
// Divider select codes (power of two) and timing counts
// ----------------------------------------------------------------
`define DIV_SEL_4           3'h2
`define DIV_SEL_16          3'h4
`define SLOW_DIV_LAST       4'h3
`define START_ADDR          16'h0000
`define WARM_EDGES          2048
`define FILT_TAPS           4

`endif

// File: logic/reset_and_clock_select.v
// Reset sequencer and system clock selector with Wishbone registers
`timescale 1ns/10ps
`include "reset_and_clock_select_defines.vh"

module reset_and_clock_select #(
  parameter WARM_CYCLES = `WARM_EDGES,
  parameter FILT_LEN    = `FILT_TAPS
) (
  input  wire        ref_clk_i,
  input  wire        nrst_i,
  // Wishbone classic slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // External reset pin and oscillator levels
  input  wire        ext_reset_n_i,
  input  wire        internal_fast_rc_i,
  input  wire        internal_slow_rc_i,
  input  wire        ext_osc_i,
  // Towards the core
  output wire        core_rst_n_o,
  output reg         init_regs_o,
  output reg         exec_start_o,
  output reg  [15:0] start_addr_o,
  output reg         fcpu_tick_o,
  output reg         rtc_tick_o
);

  // ----------------------------------------------------------------
  // Local reset release
  // ----------------------------------------------------------------
  // Async assert, sync release, so no flop leaves reset on a runt
  reg rst_meta_r;
  reg rst_sync_r;
  wire rst_n = rst_sync_r;

  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  // Binary codes double as the status state field
  localparam [1:0] ST_HOLD = 2'd0;
  localparam [1:0] ST_INIT = 2'd1;
  localparam [1:0] ST_WARM = 2'd2;
  localparam [1:0] ST_RUN  = 2'd3;

  // ----------------------------------------------------------------
  // Software visible registers
  // ----------------------------------------------------------------
  reg  [7:0] opt_r;
  reg  [7:0] ctrl_r;
  wire       pin_en      = opt_r[`OPT_PIN_EN_BIT];
  wire       filt_en     = opt_r[`OPT_FILT_EN_BIT];
  wire [2:0] high_clock_option_sel_sel    = opt_r[`OPT_HIGH_CLOCK_OPTION_SEL_MSB:`OPT_HIGH_CLOCK_OPTION_SEL_LSB];
  wire [2:0] div_sel     = opt_r[`OPT_DIV_MSB:`OPT_DIV_LSB];
  wire       slow_clock_select = ctrl_r[`CTRL_SLOW_BIT];

  // ----------------------------------------------------------------
  // High clock option decode, shared by clamp and source mux
  // ----------------------------------------------------------------
  function is_fast_rc;
    input [2:0] high_clock_option_sel;
    begin
      is_fast_rc = (high_clock_option_sel == `HIGH_CLOCK_OPTION_SEL_FAST_RC_ONLY) ||
                   (high_clock_option_sel == `HIGH_CLOCK_OPTION_SEL_FAST_RC_RTC);
    end
  endfunction

  // ----------------------------------------------------------------
  // Divider clamp, used for both the live divider and status
  // ----------------------------------------------------------------
  function [2:0] eff_div;
    input [2:0] sel;
    input [2:0] high_clock_option_sel;
    input       filt;
    reg   [2:0] d;
    begin
      d = sel;
      if (d > `DIV_SEL_16) begin
        d = `DIV_SEL_16;
      end
      if (is_fast_rc(high_clock_option_sel)) begin
        if (d < `DIV_SEL_4) begin
          d = `DIV_SEL_4;
        end
      end
      if (filt && d < `DIV_SEL_4) begin
        d = `DIV_SEL_4;
      end
      eff_div = d;
    end
  endfunction

  wire [2:0] div_eff = eff_div(div_sel, high_clock_option_sel_sel, filt_en);

  // ----------------------------------------------------------------
  // Reset pin synchroniser
  // ----------------------------------------------------------------
  // Flops reset low, so the pin counts as asserted until two real
  // samples have been taken.
  reg pin_meta_r;
  reg pin_sync_r;

  always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_r <= 1'b0;
      pin_sync_r <= 1'b0;
    end else begin
      pin_meta_r <= ext_reset_n_i;
      pin_sync_r <= pin_meta_r;
    end
  end

  // Pin low counts as reset only while the option enables it
  wire pin_hold = pin_en & ~pin_sync_r;

  // ----------------------------------------------------------------
  // Noise filter on the external oscillator
  // ----------------------------------------------------------------
  // A level is accepted only once every tap agrees, so glitches
  // shorter than the tap window never reach the divider.
  reg [FILT_LEN-1:0] filt_sh_r;
  reg                filt_lvl_r;

  always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      filt_sh_r  <= {FILT_LEN{1'b0}};
      filt_lvl_r <= 1'b0;
    end else begin
      filt_sh_r <= {filt_sh_r[FILT_LEN-2:0], ext_osc_i};
      if (&filt_sh_r) begin
        filt_lvl_r <= 1'b1;
      end else if (~|filt_sh_r) begin
        filt_lvl_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // High clock source selection and edge detection
  // ----------------------------------------------------------------
  // Codes 6 and 7 are unassigned and behave as an external source
  wire high_clock_option_sel_is_int = is_fast_rc(high_clock_option_sel_sel);
  wire ext_lvl     = filt_en ? filt_lvl_r : ext_osc_i;
  wire high_clock_option_sel_lvl    = high_clock_option_sel_is_int ? internal_fast_rc_i : ext_lvl;

  // Index 0 high source, 1 slow RC, 2 raw crystal
  wire [2:0] src_lvl = {ext_osc_i, internal_slow_rc_i, high_clock_option_sel_lvl};
  wire [2:0] src_rise;
  genvar     gi;

  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_edge
      reg prev_r;
      always @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
          prev_r <= 1'b0;
        end else begin
          prev_r <= src_lvl[gi];
        end
      end
      assign src_rise[gi] = src_lvl[gi] & ~prev_r;
    end
  endgenerate

  wire high_clock_option_sel_edge = src_rise[0];
  wire slow_edge = src_rise[1];
  wire xtal_edge = src_rise[2];

  // ----------------------------------------------------------------
  // Reset sequencer
  // ----------------------------------------------------------------
  reg [1:0]  state_r;
  reg [1:0]  state_nxt;
  reg [15:0] warm_cnt_r;
  // 16-bit count: WARM_CYCLES above 65536 is not supported
  wire [31:0] warm_last = WARM_CYCLES - 1;
  wire       warm_done = (warm_cnt_r == warm_last[15:0]);

  // A dead high oscillator never ends warm-up, so the core stays
  // in reset instead of running on a missing clock.
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_HOLD: begin
        if (!pin_hold) begin
          state_nxt = ST_INIT;
        end
      end
      ST_INIT: begin
        state_nxt = ST_WARM;
      end
      ST_WARM: begin
        if (high_clock_option_sel_edge && warm_done) begin
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
    // Pin low forces the hold in every state, also while running
    if (pin_hold) begin
      state_nxt = ST_HOLD;
    end
  end

  always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_r      <= ST_HOLD;
      warm_cnt_r   <= 16'h0000;
      init_regs_o  <= 1'b0;
      exec_start_o <= 1'b0;
      start_addr_o <= `START_ADDR;
    end else begin
      state_r      <= state_nxt;
      init_regs_o  <= (state_nxt == ST_INIT);
      exec_start_o <= (state_r == ST_WARM) && (state_nxt == ST_RUN);
      start_addr_o <= `START_ADDR;
      if (state_r != ST_WARM) begin
        warm_cnt_r <= 16'h0000;
      end else if (high_clock_option_sel_edge) begin
        warm_cnt_r <= warm_cnt_r + 16'h0001;
      end
    end
  end

  // Raw pin gates the core reset so assertion needs no clock edge;
  // release still waits for the synchronised sequence.
  assign core_rst_n_o = (state_r == ST_RUN) &
                        (~pin_en | ext_reset_n_i);

  // ----------------------------------------------------------------
  // Instruction clock divider
  // ----------------------------------------------------------------
  reg  [3:0] div_cnt_r;
  reg        mode_prev_r;
  wire [3:0] div_last = slow_clock_select ? `SLOW_DIV_LAST :
                        ((4'h1 << div_eff) - 4'h1);
  wire       src_edge = slow_clock_select ? slow_edge : high_clock_option_sel_edge;

  // Restart on a mode switch so the first slow tick is a full
  // quarter period rather than a runt.
  always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_r   <= 4'h0;
      mode_prev_r <= 1'b0;
      fcpu_tick_o <= 1'b0;
    end else begin
      mode_prev_r <= slow_clock_select;
      fcpu_tick_o <= 1'b0;
      if (state_r != ST_RUN || mode_prev_r != slow_clock_select) begin
        div_cnt_r <= 4'h0; // restart cleanly on a mode change
      end else if (src_edge) begin
        if (div_cnt_r >= div_last) begin
          div_cnt_r   <= 4'h0;
          fcpu_tick_o <= 1'b1;
        end else begin
          div_cnt_r <= div_cnt_r + 4'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Real-time tick from the external crystal
  // ----------------------------------------------------------------
  // Raw crystal on purpose: the filter guards only the system clock
  // path and would delay the RTC edge.
  always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rtc_tick_o <= 1'b0;
    end else begin
      rtc_tick_o <= (high_clock_option_sel_sel == `HIGH_CLOCK_OPTION_SEL_FAST_RC_RTC) && xtal_edge;
    end
  end

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  // Options sit in a register so a system can load its strap values
  // once at boot; the sequencer only watches them.
  wire        wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        wb_wr   = wb_req & wb_we_i & wb_sel_i[0];
  // Status: [1:0] state, [4] slow, [5] core run, [10:8] divider
  wire [31:0] stat_val = {20'h00000, 1'b0, div_eff, 2'b00,
                          core_rst_n_o, slow_clock_select,
                          2'b00, state_r};
  reg  [31:0] rd_val;

  // Holes read as zero; status is read-only
  always @* begin
    rd_val = 32'h00000000;
    if (wb_adr_i == `OPT_REG_ADDR) begin
      rd_val = {24'h000000, opt_r};
    end else if (wb_adr_i == `CTRL_REG_ADDR) begin
      rd_val = {24'h000000, ctrl_r};
    end else if (wb_adr_i == `STAT_REG_ADDR) begin
      rd_val = stat_val;
    end
  end

  always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      opt_r    <= `OPT_RESET_VAL;
      ctrl_r   <= `CTRL_RESET_VAL;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_val : 32'h00000000;
      if (wb_wr) begin
        if (wb_adr_i == `OPT_REG_ADDR) begin
          opt_r <= wb_dat_i[7:0];
        end else if (wb_adr_i == `CTRL_REG_ADDR) begin
          ctrl_r <= wb_dat_i[7:0] & 8'h04;
        end
      end
      // A pin reset returns the mode bit to the high clock as well
      if (state_nxt == ST_INIT) begin
        ctrl_r <= `CTRL_RESET_VAL;
      end
    end
  end

endmodule

// File: verification/reset_and_clock_select_chk.sv
// Port checker for the reset sequencer and clock selector
`timescale 1ns/10ps
module reset_and_clock_select_chk #(
  parameter WARM_CYCLES = 4,
  parameter FILT_LEN    = 2
) (
  input wire        ref_clk_i,
  input wire        nrst_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire        ext_reset_n_i,
  input wire        core_rst_n_o,
  input wire        init_regs_o,
  input wire        exec_start_o,
  input wire [15:0] start_addr_o,
  input wire        fcpu_tick_o,
  input wire        rtc_tick_o
);
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);

  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ans;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  sequence s_init;
    init_regs_o ##1 !init_regs_o;
  endsequence

  property p_wb_ans; s_req |=> s_ans; endproperty
  a_wb_ans: assert property (p_wb_ans) else $error("ack not single");
  property p_ack_src; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_ack_src: assert property (p_ack_src) else $error("ack unasked");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("data not idle");
  property p_addr0; start_addr_o == 16'h0000; endproperty
  a_addr0: assert property (p_addr0) else $error("start addr");
  property p_run_exec; $rose(core_rst_n_o) |-> ##[0:2] exec_start_o; endproperty
  a_run_exec: assert property (p_run_exec) else $error("no start");
  property p_run_pin; $rose(core_rst_n_o) |-> ext_reset_n_i; endproperty
  a_run_pin: assert property (p_run_pin) else $error("pin low");
  property p_exec_pulse; exec_start_o |=> !exec_start_o; endproperty
  a_exec_pulse: assert property (p_exec_pulse) else $error("start");
  // Core reset stays low for at least four clocks after init
  property p_warm; s_init |-> !core_rst_n_o [*4]; endproperty
  a_warm: assert property (p_warm) else $error("warm short");
  property p_tick; fcpu_tick_o |=> !fcpu_tick_o; endproperty
  a_tick: assert property (p_tick) else $error("tick width");
  property p_rtc; rtc_tick_o |=> !rtc_tick_o; endproperty
  a_rtc: assert property (p_rtc) else $error("rtc width");
endmodule

// File: verification/ext_reset_src.sv
// Model of the external reset circuit on the reset pin
`timescale 1ns/10ps
module ext_reset_src #(
  parameter RISE_CYCLES = 8
) (
  input  wire  clk_i,
  input  wire  hold_i,
  output logic reset_n_o = 1'b0
);
  int cnt_r = 0;
  // Slow RC-like rise; pin stays low while held
  always @(posedge clk_i) begin
    if (hold_i) begin
      cnt_r     <= 0;
      reset_n_o <= 1'b0;
    end else if (cnt_r < RISE_CYCLES) begin
      cnt_r <= cnt_r + 1;
    end else begin
      reset_n_o <= 1'b1;
    end
  end
endmodule

// File: verification/test_reset_and_clock_select.sv
// Self-checking bench for the reset sequencer and clock selector
`timescale 1ns/10ps
module test_reset_and_clock_select;
  typedef struct {
    logic [1:0]  op;
    logic [7:0]  adr;
    logic [31:0] d;
    logic [31:0] exp;
  } row_t;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [3:0]  wsel = 4'h1;
  logic [31:0] wdat = 32'h0;
  logic        fast = 1'b0;
  logic        slow = 1'b0;
  logic        osc = 1'b0;
  logic        hold = 1'b1;
  wire         pin;
  wire  [31:0] rdat;
  wire         ack;
  wire         core_rst_n;
  wire         init;
  wire         exec;
  wire  [15:0] saddr;
  wire         fcpu;
  wire         rtc;
  int          err_count = 0;
  int          compares = 0;
  int          ph = 0;
  int          cyc_n = 0;
  // Op 0 read, 1 write, 2 tick spacing, 3 rtc spacing (in clocks)
  row_t rows [29] = '{
    '{0,8'h04,0,0}, '{1,8'h0c,32'hff,0}, '{0,8'h0c,0,0}, '{2,0,0,16},
    '{1,0,32'h01,0}, '{2,0,0,16}, '{1,0,32'h09,0}, '{2,0,0,10},
    '{1,0,32'h0b,0}, '{2,0,0,40}, '{1,0,32'h0d,0}, '{2,0,0,10},
    '{1,0,32'h11,0}, '{2,0,0,10}, '{1,0,32'h95,0}, '{2,0,0,160},
    '{1,0,32'he9,0}, '{0,0,0,32'he9}, '{0,8'h08,0,32'h423},
    '{2,0,0,160}, '{1,8'h04,32'hff,0}, '{0,8'h04,0,32'h04},
    '{0,8'h08,0,32'h433}, '{2,0,0,56}, '{1,8'h04,0,0}, '{1,0,32'h45,0},
    '{3,0,0,10}, '{2,0,0,16}, '{0,8'h08,0,32'h223}};

  reset_and_clock_select #(.WARM_CYCLES(4), .FILT_LEN(2))
    reset_and_clock_select_i (.ref_clk_i(clk), .nrst_i(nrst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .ext_reset_n_i(pin), .internal_fast_rc_i(fast),
    .internal_slow_rc_i(slow), .ext_osc_i(osc),
    .core_rst_n_o(core_rst_n), .init_regs_o(init), .exec_start_o(exec),
    .start_addr_o(saddr), .fcpu_tick_o(fcpu), .rtc_tick_o(rtc));
  ext_reset_src ext_reset_src_i (.clk_i(clk), .hold_i(hold),
    .reset_n_o(pin));

  always #10 clk = ~clk;
  // Oscillator periods: fast 4, slow 14, external 10 clocks
  always @(posedge clk) begin
    ph <= ph + 1;
    if (ph % 2 == 0) fast <= ~fast;
    if (ph % 7 == 0) slow <= ~slow;
    if (ph % 5 == 0) osc <= ~osc;
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      err_count++;
      print_verdict();
    end
  end

  task check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task wb(input logic w, input logic [7:0] a, input logic [31:0] d,
          output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= wsel;
    // No cap here: a missing ack is caught by the cycle timeout
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  // Third wait is a clean interval, clear of any divider restart
  task span(input logic r, output int n);
    for (int k = 0; k < 3; k++) begin
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while ((r ? rtc : fcpu) !== 1'b1 && n < 1000);
    end
  endtask

  task wait_run;
    logic seen;
    seen = 1'b0;
    for (int n = 0; n < 300 && exec !== 1'b1; n++) begin
      @(posedge clk);
      if (init === 1'b1) seen = 1'b1;
    end
    check(32'(seen), 32'h1);
    @(posedge clk);
    check(32'(core_rst_n), 32'h1);
    check(32'(saddr), 32'h0);
  endtask

  task do_reset;
    logic [31:0] q;
    hold <= 1'b1;
    nrst <= 1'b0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (40) @(posedge clk);
    check(32'(core_rst_n), 32'h0);
    wb(1'b0, 8'h00, 32'h0, q);
    check(q, 32'h41);
    wb(1'b0, 8'h08, 32'h0, q);
    check(q, 32'h200);
    hold <= 1'b0;
    wait_run();
    $display("reset test done");
  endtask

  task print_verdict;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    logic [31:0] q;
    int n;
    do_reset();
    foreach (rows[i]) begin
      if (rows[i].op == 2'd0) begin
        wb(1'b0, rows[i].adr, 32'h0, q);
        check(q, rows[i].exp);
      end else if (rows[i].op == 2'd1) begin
        wb(1'b1, rows[i].adr, rows[i].d, q);
      end else begin
        span(rows[i].op[0], n);
        check(32'(n), rows[i].exp);
      end
    end
    $display("table test done");
    wsel = 4'h0;
    wb(1'b1, 8'h00, 32'h40, q);
    wsel = 4'h1;
    wb(1'b0, 8'h00, 32'h0, q);
    check(q, 32'h45);
    wb(1'b1, 8'h00, 32'h40, q);
    hold <= 1'b1;
    repeat (20) @(posedge clk);
    check(32'(core_rst_n), 32'h1);
    hold <= 1'b0;
    repeat (20) @(posedge clk);
    wb(1'b1, 8'h00, 32'h41, q);
    $display("pin option test done");
    wb(1'b1, 8'h04, 32'h04, q);
    hold <= 1'b1;
    repeat (2) @(posedge clk);
    check(32'(core_rst_n), 32'h0);
    hold <= 1'b0;
    wait_run();
    wb(1'b0, 8'h04, 32'h0, q);
    check(q, 32'h0);
    $display("running pin test done");
    do_reset();
    print_verdict();
  end
endmodule

bind reset_and_clock_select reset_and_clock_select_chk #(
  .WARM_CYCLES(WARM_CYCLES), .FILT_LEN(FILT_LEN)) chk_i (
  .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .ext_reset_n_i(ext_reset_n_i), .core_rst_n_o(core_rst_n_o),
  .init_regs_o(init_regs_o), .exec_start_o(exec_start_o),
  .start_addr_o(start_addr_o), .fcpu_tick_o(fcpu_tick_o),
  .rtc_tick_o(rtc_tick_o));
